// *** rtl/ctl_pkg.sv ***
// Constants shared by the serial control port, its register bank and IRQs.
`default_nettype none

package ctl_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE     = 7'h00;
  localparam logic [6:0] ADDR_IRQ_STAT = 7'h12;
  localparam logic [6:0] ADDR_IRQ_EN   = 7'h15;
  localparam logic [6:0] ADDR_IND_DATA = 7'h1D;
  localparam logic [6:0] ADDR_IND_ADDR = 7'h1E;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int         MODE_CHAIN_BIT   = 7;
  localparam int         MODE_RELEASE_BIT = 6;
  localparam logic [7:0] MODE_RST         = 8'h00;
  localparam logic [7:0] IND_RST          = 8'h00;
  localparam int         IRQ_REGS         = 3;
  localparam int         IRQ_SOURCES      = 13;
  localparam logic [23:0] IRQ_IMPL_MASK   = 24'h0307FF;

  // Byte phase of the serial frame.
  typedef enum logic [1:0] {
    PH_SEL  = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

endpackage

`default_nettype wire

// *** rtl/reg_wr_if.sv ***
// Write path and interrupt register view between bank and interrupt logic.
`timescale 1ns/100ps
`default_nettype none

interface reg_wr_if;
  logic        wr_en;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [23:0] stat;
  logic [23:0] en;

  modport bank (output wr_en, output addr, output wdata,
                input stat, input en);
  modport irq  (input wr_en, input addr, input wdata,
                output stat, output en);
endinterface

`default_nettype wire

// *** rtl/sync_bits.sv ***
// Two-flop level synchroniser.
`timescale 1ns/100ps
`default_nettype none

module sync_bits #(
  parameter int W = 2
) (
  // Clock and reset of the receiving domain.
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // Level from the other domain and its synchronised copy.
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage is visible outside.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

`default_nettype wire

// *** rtl/irq_ctrl.sv ***
// Interrupt status and enable registers.
`timescale 1ns/100ps
`default_nettype none

module irq_ctrl (
  // System clock and reset.
  input  wire logic                           clk_in,
  input  wire logic                           rst_b_in,
  // Event pulses, one per source.
  input  wire logic [ctl_pkg::IRQ_SOURCES-1:0] src_in,
  // Register access.
  reg_wr_if.irq                               bus
);

  logic [23:0] stat_q;
  logic [23:0] stat_d;
  logic [23:0] en_q;
  logic [23:0] en_d;
  logic [23:0] src_w;
  logic [23:0] clr_w;
  logic [23:0] ewr_w;
  logic [23:0] ewm_w;

  // Sources 0-7 in the first register, 8-10 and 11-12 in the next two.
  assign src_w = {6'h00, src_in[12:11], 5'h00, src_in[10:8], src_in[7:0]};

  // Per-register write decode of clear masks and enable values.
  genvar k;
  generate
    for (k = 0; k < ctl_pkg::IRQ_REGS; k++) begin : g_reg
      assign clr_w[8*k +: 8] = (bus.wr_en && bus.addr ==
        ctl_pkg::ADDR_IRQ_STAT + 7'(k)) ? bus.wdata : 8'h00;
      assign ewm_w[8*k +: 8] = (bus.wr_en && bus.addr ==
        ctl_pkg::ADDR_IRQ_EN + 7'(k)) ? 8'hFF : 8'h00;
      assign ewr_w[8*k +: 8] = bus.wdata;
    end
  endgenerate

  // A new enabled event wins over a clear in the same cycle.
  always_comb begin
    stat_d = ((stat_q & ~clr_w) | (src_w & en_q))
             & ctl_pkg::IRQ_IMPL_MASK;
    en_d   = ((en_q & ~ewm_w) | (ewr_w & ewm_w)) & ctl_pkg::IRQ_IMPL_MASK;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stat_q <= 24'h000000;
      en_q   <= 24'h000000;
    end else begin
      stat_q <= stat_d;
      en_q   <= en_d;
    end
  end

  assign bus.stat = stat_q;
  assign bus.en   = en_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_SET_WHEN_ENABLED: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (src_w & en_q) != 24'h000000
    |=> (stat_q & $past(src_w & en_q)) == $past(src_w & en_q))
    else $error("Enabled event did not set its status bit.");

  AST_NO_SET_DISABLED: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ##1 (stat_q & ~$past(stat_q) & ~$past(en_q)) == 24'h000000)
    else $error("Status bit set while its enable was clear.");

  AST_W1C_CLEARS: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (clr_w != 24'h000000) && ((src_w & en_q & clr_w) == 24'h000000)
    |=> (stat_q & $past(clr_w)) == 24'h000000)
    else $error("Writing one did not clear the status bit.");

  AST_W0_KEEPS: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ##1 (($past(stat_q) & ~$past(clr_w)) & ~stat_q) == 24'h000000)
    else $error("Status bit lost without a one being written.");

  COV_EVENT_SET: cover property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(|stat_q));

endmodule

`default_nettype wire

// *** rtl/serial_ctrl_port.sv ***
// Serial control port with register bank and interrupt output.
`timescale 1ns/100ps
`default_nettype none

module serial_ctrl_port (
  // System clock domain.
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Serial link, clocked by the host.
  input  wire logic        sclk_in,
  input  wire logic        cs_b_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  output logic             serial_pass_through_out,
  // Event sources and interrupt.
  input  wire logic [11:0] event_in,
  output logic             irq_b_out,
  // Indirect register access window.
  output logic [7:0]       ind_addr_out,
  output logic [7:0]       ind_wdata_out,
  output logic             ind_req_out,
  input  wire logic [7:0]  ind_rdata_in,
  input  wire logic        ind_done_in
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  reg_wr_if ifc ();

  ctl_pkg::phase_t ph_q;
  ctl_pkg::phase_t ph_d;
  logic [2:0]  bit_cnt_q;
  logic [2:0]  bit_cnt_d;
  logic [6:0]  shift_q;
  logic [6:0]  shift_d;
  logic [7:0]  byte_w;
  logic        sel_q;
  logic        sel_d;
  logic        rd_q;
  logic        rd_d;
  logic [6:0]  addr_q;
  logic [6:0]  addr_d;
  logic [6:0]  wa_q;
  logic [6:0]  wa_d;
  logic [7:0]  wd_q;
  logic [7:0]  wd_d;
  logic        wt_q;
  logic        wt_d;
  logic        rt_q;
  logic        rt_d;
  logic        pass_q;
  logic [1:0]  cfg_s;
  logic        chain_s;
  logic        rel_s;
  logic        oe_q;
  logic        oe_d;
  logic        sdo_q;
  logic        sdo_d;
  logic [6:0]  osh_q;
  logic [6:0]  osh_d;
  logic [2:0]  left_q;
  logic [2:0]  left_d;
  logic        start_w;
  logic [1:0]  tog_s;
  logic [1:0]  tog_q;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  mode_q;
  logic [7:0]  mode_d;
  logic [7:0]  ind_addr_q;
  logic [7:0]  ind_addr_d;
  logic [7:0]  ind_data_q;
  logic [7:0]  ind_data_d;
  logic        ind_req_q;
  logic        ind_req_d;
  logic [7:0]  rd_word_q;
  logic [7:0]  rd_word_d;
  logic        irq_b_q;
  logic        irq_b_d;

  // Returns true when an address falls in a three-register bank at base.
  function automatic logic in_bank(input logic [6:0] a,
                                   input logic [6:0] base);
    in_bank = (a >= base) && (a < base + 7'(ctl_pkg::IRQ_REGS));
  endfunction

  // Read decode of every register in the bank; unmapped reads give zero.
  function automatic logic [7:0] reg_read(input logic [6:0]  a,
                                          input logic [7:0]  mode,
                                          input logic [7:0]  iaddr,
                                          input logic [7:0]  idata,
                                          input logic [23:0] stat,
                                          input logic [23:0] en);
    logic [6:0] off;
    off = 7'h00;
    reg_read = 8'h00;
    if (a == ctl_pkg::ADDR_MODE) begin
      reg_read = mode;
    end else if (a == ctl_pkg::ADDR_IND_DATA) begin
      reg_read = idata;
    end else if (a == ctl_pkg::ADDR_IND_ADDR) begin
      reg_read = iaddr;
    end else if (in_bank(a, ctl_pkg::ADDR_IRQ_STAT)) begin
      off = a - ctl_pkg::ADDR_IRQ_STAT;
      reg_read = stat[8*off[1:0] +: 8];
    end else if (in_bank(a, ctl_pkg::ADDR_IRQ_EN)) begin
      off = a - ctl_pkg::ADDR_IRQ_EN;
      reg_read = en[8*off[1:0] +: 8];
    end
  endfunction

  // ------------------------------------------------------------------
  // Link domain: byte framing on the serial clock rising edge
  // ------------------------------------------------------------------
  // Mode bits are quasi-static, so a level synchroniser is enough.
  sync_bits #(.W(2)) u_cfg_sync (
    .clk_in   (sclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (mode_q[ctl_pkg::MODE_CHAIN_BIT:ctl_pkg::MODE_RELEASE_BIT]),
    .q_out    (cfg_s)
  );
  assign chain_s = cfg_s[1];
  assign rel_s   = cfg_s[0];
  assign byte_w  = {shift_q, sdi_in};

  // Input is sampled on the rising edge; a completed byte advances phase.
  always_comb begin
    bit_cnt_d = bit_cnt_q + 3'h1;
    shift_d   = byte_w[6:0];
    ph_d      = ph_q;
    sel_d     = sel_q;
    rd_d      = rd_q;
    addr_d    = addr_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    wt_d      = wt_q;
    rt_d      = rt_q;
    if (bit_cnt_q == 3'h7) begin
      case (ph_q)
        ctl_pkg::PH_SEL: begin
          sel_d = byte_w[0];
          ph_d  = ctl_pkg::PH_CMD;
        end
        ctl_pkg::PH_CMD: begin
          rd_d   = byte_w[7];
          addr_d = byte_w[6:0];
          ph_d   = ctl_pkg::PH_DATA;
          if (byte_w[7] && sel_q) begin
            rt_d = ~rt_q;
          end
        end
        ctl_pkg::PH_DATA: begin
          // Read data bits on the input are not used.
          if (!rd_q && sel_q) begin
            wa_d = addr_q;
            wd_d = byte_w;
            wt_d = ~wt_q;
          end
          if (chain_s) begin
            ph_d = ctl_pkg::PH_SEL;
          end else begin
            ph_d  = ctl_pkg::PH_CMD;
            sel_d = 1'b1;
          end
        end
        default: ph_d = ctl_pkg::PH_CMD;
      endcase
    end
  end

  // Chip select high holds the bit count at zero, so its falling edge
  // always starts a fresh byte even after a framing slip.
  always_ff @(posedge sclk_in or negedge rst_b_in or posedge cs_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_q <= 3'h0;
    end else if (cs_b_in) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // Phase survives chip select gaps; only reset clears it.
  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ph_q    <= ctl_pkg::PH_CMD;
      shift_q <= 7'h00;
      sel_q   <= 1'b1;
      rd_q    <= 1'b0;
      addr_q  <= 7'h00;
      wa_q    <= 7'h00;
      wd_q    <= 8'h00;
      wt_q    <= 1'b0;
      rt_q    <= 1'b0;
      pass_q  <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      shift_q <= shift_d;
      sel_q   <= sel_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
      wt_q    <= wt_d;
      rt_q    <= rt_d;
      pass_q  <= sdi_in;
    end
  end

  // Select byte leaves one bit late, i.e. shifted right; others pass
  // straight through so the next device keeps the same framing.
  assign serial_pass_through_out = (chain_s && ph_q == ctl_pkg::PH_SEL)
                                   ? pass_q : sdi_in;

  // ------------------------------------------------------------------
  // Link domain: read data launched on the serial clock falling edge
  // ------------------------------------------------------------------
  assign start_w = (ph_q == ctl_pkg::PH_DATA) && rd_q && sel_q
                   && (bit_cnt_q == 3'h0);

  // The read word is loaded at the first falling edge of the data phase; the
  // chip-select gap gives the system domain time to settle it.
  always_comb begin
    oe_d   = oe_q;
    sdo_d  = sdo_q;
    osh_d  = osh_q;
    left_d = left_q;
    if (ph_q == ctl_pkg::PH_DATA && !rd_q) begin
      oe_d = 1'b0;
    end else if (!oe_q) begin
      if (start_w) begin
        oe_d   = 1'b1;
        sdo_d  = rd_word_q[7];
        osh_d  = rd_word_q[6:0];
        left_d = 3'h7;
      end
    end else if (left_q != 3'h0) begin
      sdo_d  = osh_q[6];
      osh_d  = {osh_q[5:0], 1'b0};
      left_d = left_q - 3'h1;
    end else if (!rel_s) begin
      oe_d = 1'b0;
    end
  end

  // Chip select rising always releases the output.
  always_ff @(negedge sclk_in or negedge rst_b_in or posedge cs_b_in) begin
    if (!rst_b_in) begin
      oe_q   <= 1'b0;
      sdo_q  <= 1'b0;
      osh_q  <= 7'h00;
      left_q <= 3'h0;
    end else if (cs_b_in) begin
      oe_q   <= 1'b0;
      sdo_q  <= 1'b0;
      osh_q  <= 7'h00;
      left_q <= 3'h0;
    end else begin
      oe_q   <= oe_d;
      sdo_q  <= sdo_d;
      osh_q  <= osh_d;
      left_q <= left_d;
    end
  end

  assign sdo_out    = sdo_q;
  assign sdo_oe_out = oe_q;

  // ------------------------------------------------------------------
  // System domain: register bank
  // ------------------------------------------------------------------
  // Toggles carry write and read events; their words are held stable.
  sync_bits #(.W(2)) u_tog_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({wt_q, rt_q}),
    .q_out    (tog_s)
  );
  assign wr_go     = tog_s[1] ^ tog_q[1];
  assign rd_go     = tog_s[0] ^ tog_q[0];
  assign ifc.wr_en = wr_go;
  assign ifc.addr  = wa_q;
  assign ifc.wdata = wd_q;

  irq_ctrl u_irq (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .src_in   ({ind_done_in, event_in}),
    .bus      (ifc.irq)
  );

  // Writes, indirect window and the read word presented to the link.
  always_comb begin
    mode_d     = mode_q;
    ind_addr_d = ind_addr_q;
    ind_data_d = ind_data_q;
    ind_req_d  = 1'b0;
    rd_word_d  = rd_word_q;
    if (wr_go && wa_q == ctl_pkg::ADDR_MODE) begin
      mode_d = wd_q;
    end
    if (wr_go && wa_q == ctl_pkg::ADDR_IND_DATA) begin
      ind_data_d = wd_q;
    end
    if (wr_go && wa_q == ctl_pkg::ADDR_IND_ADDR) begin
      ind_addr_d = wd_q;
      ind_req_d  = 1'b1;
    end
    if (ind_done_in) begin
      ind_data_d = ind_rdata_in;
    end
    if (rd_go) begin
      rd_word_d = reg_read(addr_q, mode_q, ind_addr_q, ind_data_q,
                           ifc.stat, ifc.en);
    end
    irq_b_d = ~(|ifc.stat);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog_q      <= 2'h0;
      mode_q     <= ctl_pkg::MODE_RST;
      ind_addr_q <= ctl_pkg::IND_RST;
      ind_data_q <= ctl_pkg::IND_RST;
      ind_req_q  <= 1'b0;
      rd_word_q  <= 8'h00;
      irq_b_q    <= 1'b1;
    end else begin
      tog_q      <= tog_s;
      mode_q     <= mode_d;
      ind_addr_q <= ind_addr_d;
      ind_data_q <= ind_data_d;
      ind_req_q  <= ind_req_d;
      rd_word_q  <= rd_word_d;
      irq_b_q    <= irq_b_d;
    end
  end

  assign irq_b_out     = irq_b_q;
  assign ind_addr_out  = ind_addr_q;
  assign ind_wdata_out = ind_data_q;
  assign ind_req_out   = ind_req_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_IRQ_LOW: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ifc.stat != 24'h000000) |=> !irq_b_out)
    else $error("Interrupt not low with a status bit set.");

  AST_IRQ_HIGH: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ifc.stat == 24'h000000) |=> irq_b_out)
    else $error("Interrupt low with all status bits clear.");

  AST_MODE_WRITE: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wr_go && (wa_q == ctl_pkg::ADDR_MODE) |=> mode_q == $past(wd_q))
    else $error("Mode register write not applied.");

  AST_CMD_DECODE: assert property (
    @(posedge sclk_in) disable iff (!rst_b_in)
    (ph_q == ctl_pkg::PH_CMD) && (bit_cnt_q == 3'h7) && !cs_b_in
    |=> (rd_q == $past(shift_q[6])) && (ph_q == ctl_pkg::PH_DATA))
    else $error("Command byte direction or phase wrong.");

  AST_CS_RESYNC: assert property (
    @(negedge cs_b_in) disable iff (!rst_b_in)
    (bit_cnt_q == 3'h0) && !oe_q)
    else $error("Byte count not realigned at select fall.");

  AST_SDO_MSB: assert property (
    @(negedge sclk_in) disable iff (!rst_b_in || cs_b_in)
    $rose(oe_q) |-> (sdo_q == rd_word_q[7]) && (left_q == 3'h7))
    else $error("Read data did not start with the MSB.");

  AST_SDO_RELEASE: assert property (
    @(negedge sclk_in) disable iff (!rst_b_in || cs_b_in)
    oe_q && (left_q == 3'h0) && !rel_s && (ph_q != ctl_pkg::PH_DATA)
    |=> !oe_q)
    else $error("Output not released after the last bit.");

  AST_WRITE_HIZ: assert property (
    @(negedge sclk_in) disable iff (!rst_b_in || cs_b_in)
    (ph_q == ctl_pkg::PH_DATA) && !rd_q && (bit_cnt_q != 3'h0) |-> !oe_q)
    else $error("Output driven during a write.");

  AST_PASS_DELAY: assert property (
    @(posedge sclk_in) disable iff (!rst_b_in || cs_b_in)
    chain_s && (ph_q == ctl_pkg::PH_SEL) && (bit_cnt_q != 3'h0)
    |-> serial_pass_through_out == $past(sdi_in))
    else $error("Pass-through not one clock behind input.");

  AST_CHAIN_SEL: assert property (
    @(posedge sclk_in) disable iff (!rst_b_in)
    (ph_q == ctl_pkg::PH_SEL) && (bit_cnt_q == 3'h7) && !cs_b_in
    |=> (sel_q == $past(sdi_in)) && (ph_q == ctl_pkg::PH_CMD))
    else $error("Chain select bit not taken from the LSB.");

  COV_READ: cover property (
    @(negedge sclk_in) disable iff (!rst_b_in) $rose(oe_q));

  COV_WRITE: cover property (
    @(posedge clk_in) disable iff (!rst_b_in) wr_go);

  COV_CHAIN: cover property (
    @(posedge sclk_in) disable iff (!rst_b_in)
    chain_s && (ph_q == ctl_pkg::PH_SEL) && (bit_cnt_q == 3'h7));

endmodule

`default_nettype wire

// *** bench/spi_host_model.sv ***
// Host side serial master model for the control port.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Lines driven by the host.
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      sdi_out,
  // Lines seen by the host.
  input  wire logic sdo_in,
  input  wire logic oe_in,
  input  wire logic thru_in
);
  // -----------------------------------------------------------------
  // Byte transfer
  // -----------------------------------------------------------------
  logic [7:0] thru_q;
  logic       oe_end_q;
  // Set by the bench to add one falling edge after the last bit.
  logic       tail_q = 1'b0;

  // Clock parks high and select stays released between frames.
  initial begin
    sclk_out = 1'b1;
    cs_b_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // One byte MSB first; fewer than eight bits makes a broken frame.
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx       = 8'h00;
    cs_b_out = 1'b0;
    #100;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk_out = 1'b0;
      sdi_out  = tx[i];
      #62.5;
      // A released output reads as its inverse, so a lost drive shows.
      rx[i]     = oe_in ? sdo_in : ~sdo_in;
      thru_q[i] = thru_in;
      sclk_out  = 1'b1;
      #62.5;
    end
    // Free-running style tail: one more falling edge with select low.
    if (tail_q) begin
      sclk_out = 1'b0;
      #62.5;
      sclk_out = 1'b1;
    end
    #100;
    oe_end_q = oe_in;
    // The released line must not keep its last value.
    cs_b_out = 1'b1;
    sdi_out  = ~sdi_out;
    #600;
  endtask
endmodule
`default_nettype wire

// *** bench/serial_ctrl_port_bench.sv ***
// Self-checking bench for the serial control port.
`timescale 1ns/100ps
`default_nettype none
module serial_ctrl_port_bench;
  // -----------------------------------------------------------------
  // Harness
  // -----------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        sclk, cs_b, sdi, sdo, oe, thru, irq_b, ind_req, ind_done;
  logic [11:0] event_in = 12'h000;
  logic [7:0]  ind_addr, ind_wdata, ind_rdata, r;
  logic        tail = 1'b0;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          req_cnt = 0;

  // Clock of the system domain.
  always #50 clk_in = ~clk_in;

  serial_ctrl_port dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sclk_in(sclk), .cs_b_in(cs_b), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_oe_out(oe), .serial_pass_through_out(thru),
    .event_in(event_in), .irq_b_out(irq_b), .ind_addr_out(ind_addr),
    .ind_wdata_out(ind_wdata), .ind_req_out(ind_req),
    .ind_rdata_in(ind_rdata), .ind_done_in(ind_done));
  spi_host_model host (.sclk_out(sclk), .cs_b_out(cs_b), .sdi_out(sdi),
    .sdo_in(sdo), .oe_in(oe), .thru_in(thru));

  // Counts request pulses and cuts a hang short.
  always @(posedge clk_in) begin
    cycles++;
    if (ind_req === 1'b1) req_cnt++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // -----------------------------------------------------------------
  // Access helpers; sel of 0 means a plain two-byte access.
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] sel, input logic [6:0] a,
                    input logic [7:0] d);
    if (sel != 8'h00) host.xfer(sel, 8, r);
    host.xfer({1'b0, a}, 8, r);
    host.xfer(d, 8, r);
    check({7'h00, host.oe_end_q}, 8'h00);
  endtask

  task automatic rd(input logic [7:0] sel, input logic [6:0] a,
                    input logic [7:0] exp);
    if (sel != 8'h00) host.xfer(sel, 8, r);
    host.xfer({1'b1, a}, 8, r);
    // All ones on the data byte stand for a released, pulled-up wire.
    host.tail_q = tail;
    host.xfer(8'hFF, 8, r);
    host.tail_q = 1'b0;
    check(r, exp);
  endtask

  task automatic pulse(input logic [11:0] ev, input logic done);
    @(posedge clk_in) #1;
    event_in = ev;
    ind_done = done;
    @(posedge clk_in) #1;
    event_in = 12'h000;
    ind_done = 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_regs();
    check({7'h00, irq_b}, 8'h01);
    rd(8'h00, ctl_pkg::ADDR_MODE, ctl_pkg::MODE_RST);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, ctl_pkg::ADDR_IRQ_EN + 7'(i), 8'hFF);
      rd(8'h00, ctl_pkg::ADDR_IRQ_EN + 7'(i),
         ctl_pkg::IRQ_IMPL_MASK[8*i +: 8]);
    end
    rd(8'h00, 7'h7F, 8'h00);
    host.xfer(8'hFF, 3, r);
    rd(8'h00, ctl_pkg::ADDR_IRQ_EN, 8'hFF);
  endtask

  task automatic t_irq();
    wr(8'h00, ctl_pkg::ADDR_IRQ_EN, 8'h01);
    pulse(12'h003, 1'b0);
    check({7'h00, irq_b}, 8'h00);
    rd(8'h00, ctl_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(8'h00, ctl_pkg::ADDR_IRQ_STAT, 8'h00);
    rd(8'h00, ctl_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(8'h00, ctl_pkg::ADDR_IRQ_STAT, 8'h01);
    rd(8'h00, ctl_pkg::ADDR_IRQ_STAT, 8'h00);
    check({7'h00, irq_b}, 8'h01);
  endtask

  task automatic t_ind();
    wr(8'h00, ctl_pkg::ADDR_IND_ADDR, 8'hA5);
    wr(8'h00, ctl_pkg::ADDR_IND_DATA, 8'h96);
    check(ind_addr, 8'hA5);
    check(ind_wdata, 8'h96);
    check(8'(req_cnt), 8'h01);
    ind_rdata = 8'h3C;
    pulse(12'h000, 1'b1);
    rd(8'h00, ctl_pkg::ADDR_IND_DATA, 8'h3C);
    rd(8'h00, ctl_pkg::ADDR_IRQ_STAT + 7'h02, 8'h02);
    wr(8'h00, ctl_pkg::ADDR_IRQ_STAT + 7'h02, 8'h02);
  endtask

  task automatic t_chain();
    tail = 1'b1;
    rd(8'h00, ctl_pkg::ADDR_IND_DATA, 8'h3C);
    check({7'h00, host.oe_end_q}, 8'h00);
    wr(8'h00, ctl_pkg::ADDR_MODE, 8'h40);
    rd(8'h00, ctl_pkg::ADDR_IND_DATA, 8'h3C);
    tail = 1'b0;
    check({7'h00, host.oe_end_q}, 8'h01);
    check({7'h00, oe}, 8'h00);
    wr(8'h00, ctl_pkg::ADDR_MODE, 8'h80);
    rd(8'h00, ctl_pkg::ADDR_MODE, 8'h80);
    host.xfer(8'hB5, 8, r);
    check({1'b0, host.thru_q[6:0]}, 8'h5A);
    wr(8'h00, ctl_pkg::ADDR_IRQ_EN, 8'h3C);
    check(host.thru_q, 8'h3C);
    wr(8'h02, ctl_pkg::ADDR_IRQ_EN, 8'h11);
    rd(8'hB5, ctl_pkg::ADDR_IRQ_EN, 8'h3C);
  endtask

  // Main sequence: reset held for twenty cycles, then each scenario.
  initial begin
    ind_done  = 1'b0;
    ind_rdata = 8'h00;
    repeat (20) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_irq();
    t_ind();
    t_chain();
    give_verdict();
  end
endmodule
`default_nettype wire
